// ---- rtl/hplsb_pkg.sv ----
// Shared constants, field positions and carrier types for the host page, lock and status bank.
package hplsb_pkg;

  // Address space seen by the serial host: page number above a 7-bit byte offset.
  localparam int OFFS_W = 7;
  localparam int PAGE_W = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = PAGE_W + OFFS_W;

  // Register addresses (page and offset combined).
  localparam logic [ADDR_W-1:0] ADDR_MON_ONE   = 15'h016F;
  localparam logic [ADDR_W-1:0] ADDR_MON_TWO   = 15'h0170;
  localparam logic [ADDR_W-1:0] ADDR_MON_THREE = 15'h0171;
  localparam logic [ADDR_W-1:0] ADDR_GUARD     = 15'h017E;
  localparam logic [ADDR_W-1:0] ADDR_PAGE      = 15'h017F;

  // The page selector is also reachable at this offset on every page.
  localparam logic [OFFS_W-1:0] PAGE_REG_OFFSET = 7'h7F;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_MON   = 8'h00;
  localparam logic [DATA_W-1:0] RST_GUARD = 8'h00;
  localparam logic [PAGE_W-1:0] RST_PAGE  = 8'h00;

  // Field positions of the monitor status registers and of the guard register.
  localparam int MON_ALIGN_LSB  = 4;
  localparam int MON_UNLOCK_BIT = 2;
  localparam int GUARD_FAIL_BIT = 0;

  // Divider counts per monitor register.
  localparam int MON_DIV_FULL  = 4;
  localparam int MON_DIV_SHORT = 2;

  // Page codes that name no page, and the highest page code that names one.
  localparam logic [PAGE_W-1:0] PAGE_RSV_LOW  = 8'h07;
  localparam logic [PAGE_W-1:0] PAGE_RSV_MID  = 8'h09;
  localparam logic [PAGE_W-1:0] PAGE_LAST     = 8'h0D;

  // One host request from the serial front end.
  typedef struct packed {
    logic              write;
    logic [OFFS_W-1:0] offset;
    logic [DATA_W-1:0] wdata;
  } hplsb_req_t;

  // Raw state of one synthesizer as reported by its monitor.
  typedef struct packed {
    logic [3:0] align_done;
    logic [3:0] out_enable;
    logic       synth_enable;
    logic       synthesizer_unlocked;
  } hplsb_mon_t;

  // True for page codes that select a real 128-byte page.
  function automatic logic page_code_valid(input logic [PAGE_W-1:0] code);
    page_code_valid = (code <= PAGE_LAST) && (code != PAGE_RSV_LOW) && (code != PAGE_RSV_MID);
  endfunction

endpackage

// ---- rtl/hplsb_synth_mon.sv ----
// Synchroniser and status byte builder for one synthesizer monitor register.
`timescale 1ns/100ps
module hplsb_synth_mon #(
  parameter int NUM_DIV = 4
) (
  // Clock and reset.
  input  wire logic                          core_clk_in,
  input  wire logic                          resetn_in,
  // Raw monitor state from the synthesizer.
  input  wire hplsb_pkg::hplsb_mon_t         mon_in,
  // Formatted status byte.
  output logic [hplsb_pkg::DATA_W-1:0]       status_out
);

  // A status byte has room for at most four divider flags.
  if (NUM_DIV < 1 || NUM_DIV > 4) begin : g_num_div_check
    $error("hplsb_synth_mon: NUM_DIV must be 1 to 4");
  end

  hplsb_pkg::hplsb_mon_t            meta_r;
  hplsb_pkg::hplsb_mon_t            sync_r;
  logic [3:0]                       div_mask;
  logic [3:0]                       align_live;
  logic [hplsb_pkg::DATA_W-1:0]     status_nxt;

  // The monitor runs off the synthesizer clocks, so every bit crosses two flops.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= mon_in;
      sync_r <= meta_r;
    end
  end

  assign div_mask   = 4'((5'h01 << NUM_DIV) - 5'h01);
  // A done flag drops as soon as its output or the whole synthesizer is disabled.
  assign align_live = sync_r.align_done & sync_r.out_enable & {4{sync_r.synth_enable}} & div_mask;

  always_comb begin
    status_nxt = hplsb_pkg::RST_MON;
    status_nxt[hplsb_pkg::MON_ALIGN_LSB +: 4]  = align_live;
    status_nxt[hplsb_pkg::MON_UNLOCK_BIT]      = sync_r.synthesizer_unlocked;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= hplsb_pkg::RST_MON;
    end else begin
      status_out <= status_nxt;
    end
  end

endmodule

// ---- rtl/hplsb_bank.sv ----
// Host page select, write lockout, access status and synthesizer monitor registers.
`timescale 1ns/100ps
module hplsb_bank (
  // Clock and reset.
  input  wire logic                             core_clk_in,
  input  wire logic                             resetn_in,
  // Host requests from the serial front end.
  input  wire logic                             req_valid_in,
  input  wire hplsb_pkg::hplsb_req_t            req_in,
  input  wire logic                             access_fail_in,
  // Synthesizer monitors one to three.
  input  wire hplsb_pkg::hplsb_mon_t            mon_one_in,
  input  wire hplsb_pkg::hplsb_mon_t            mon_two_in,
  input  wire hplsb_pkg::hplsb_mon_t            mon_three_in,
  // Answers to the front end.
  output logic                                  rsp_valid_out,
  output logic                                  rsp_hit_out,
  output logic [hplsb_pkg::DATA_W-1:0]          rsp_rdata_out,
  // Bank state for the rest of the device.
  output logic [hplsb_pkg::PAGE_W-1:0]          page_out,
  output logic                                  lock_active_out
);

  logic [hplsb_pkg::DATA_W-1:0]  mon_one;
  logic [hplsb_pkg::DATA_W-1:0]  mon_two;
  logic [hplsb_pkg::DATA_W-1:0]  mon_three;

  logic [hplsb_pkg::PAGE_W-1:0]  page_r;
  logic [hplsb_pkg::PAGE_W-1:0]  page_nxt;
  logic [hplsb_pkg::DATA_W-1:0]  lockout_r;
  logic [hplsb_pkg::DATA_W-1:0]  lockout_nxt;
  logic                          fail_r;
  logic                          fail_nxt;
  logic                          rsp_valid_r;
  logic                          rsp_hit_r;
  logic [hplsb_pkg::DATA_W-1:0]  rsp_rdata_r;
  logic [hplsb_pkg::DATA_W-1:0]  rsp_rdata_nxt;
  logic                          lock_active_r;

  wire [hplsb_pkg::ADDR_W-1:0]   full_addr;
  wire                           hit_mon_one;
  wire                           hit_mon_two;
  wire                           hit_mon_three;
  wire                           hit_guard;
  wire                           hit_page;
  wire                           hit_any;
  wire                           wr_req;
  wire                           lock_on;
  wire                           page_code_ok;
  wire                           page_wr_ok;
  wire                           page_wr_reject;
  wire                           access_bad;
  wire                           access_good;
  wire [hplsb_pkg::DATA_W-1:0]   guard_view;
  wire [hplsb_pkg::DATA_W-1:0]   rd_mux;

  hplsb_synth_mon #(
    .NUM_DIV (hplsb_pkg::MON_DIV_FULL)
  ) u_mon_one (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .mon_in      (mon_one_in),
    .status_out  (mon_one)
  );

  hplsb_synth_mon #(
    .NUM_DIV (hplsb_pkg::MON_DIV_FULL)
  ) u_mon_two (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .mon_in      (mon_two_in),
    .status_out  (mon_two)
  );

  // The third synthesizer has only dividers B and A.
  hplsb_synth_mon #(
    .NUM_DIV (hplsb_pkg::MON_DIV_SHORT)
  ) u_mon_three (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .mon_in      (mon_three_in),
    .status_out  (mon_three)
  );

  // The current page supplies the upper address bits of every request.
  assign full_addr     = {page_r, req_in.offset};
  assign hit_mon_one   = (full_addr == hplsb_pkg::ADDR_MON_ONE);
  assign hit_mon_two   = (full_addr == hplsb_pkg::ADDR_MON_TWO);
  assign hit_mon_three = (full_addr == hplsb_pkg::ADDR_MON_THREE);
  assign hit_guard     = (full_addr == hplsb_pkg::ADDR_GUARD);
  // The selector answers on every page so the host can never strand itself.
  assign hit_page      = (req_in.offset == hplsb_pkg::PAGE_REG_OFFSET);
  assign hit_any       = hit_mon_one | hit_mon_two | hit_mon_three | hit_guard | hit_page;

  assign wr_req        = req_valid_in & req_in.write;
  assign lock_on       = |lockout_r;
  assign page_code_ok  = hplsb_pkg::page_code_valid(req_in.wdata);
  assign page_wr_ok    = wr_req & hit_page & ~lock_on & page_code_ok;
  assign page_wr_reject = wr_req & hit_page & (lock_on | ~page_code_ok);

  // A refused write counts as a failed access just like a front-end error.
  assign access_bad    = access_fail_in | page_wr_reject;
  assign access_good   = req_valid_in & ~access_bad;

  // The lockout value itself is write-only; the guard reads back only the failure bit.
  assign guard_view    = {{(hplsb_pkg::DATA_W-1){1'b0}}, fail_r};

  assign rd_mux = hit_mon_one   ? mon_one   :
                  hit_mon_two   ? mon_two   :
                  hit_mon_three ? mon_three :
                  hit_guard     ? guard_view :
                  hit_page      ? page_r    :
                  hplsb_pkg::RST_MON;

  always_comb begin
    page_nxt = page_r;
    if (page_wr_ok) begin
      page_nxt = req_in.wdata;
    end
  end

  always_comb begin
    lockout_nxt = lockout_r;
    if (wr_req && hit_guard) begin
      lockout_nxt = req_in.wdata;
    end
  end

  // A failure in the same cycle as a success wins.
  always_comb begin
    fail_nxt = fail_r;
    if (access_bad) begin
      fail_nxt = 1'b1;
    end else if (access_good) begin
      fail_nxt = 1'b0;
    end
  end

  always_comb begin
    rsp_rdata_nxt = rsp_rdata_r;
    if (req_valid_in) begin
      rsp_rdata_nxt = req_in.write ? hplsb_pkg::RST_MON : rd_mux;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      page_r        <= hplsb_pkg::RST_PAGE;
      lockout_r     <= hplsb_pkg::RST_GUARD;
      fail_r        <= 1'b0;
      lock_active_r <= 1'b0;
    end else begin
      page_r        <= page_nxt;
      lockout_r     <= lockout_nxt;
      fail_r        <= fail_nxt;
      lock_active_r <= |lockout_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_r <= 1'b0;
      rsp_hit_r   <= 1'b0;
      rsp_rdata_r <= hplsb_pkg::RST_MON;
    end else begin
      rsp_valid_r <= req_valid_in;
      rsp_hit_r   <= req_valid_in & hit_any;
      rsp_rdata_r <= rsp_rdata_nxt;
    end
  end

  assign rsp_valid_out   = rsp_valid_r;
  assign rsp_hit_out     = rsp_hit_r;
  assign rsp_rdata_out   = rsp_rdata_r;
  assign page_out        = page_r;
  assign lock_active_out = lock_active_r;

endmodule

// ---- sim/hplsb_bank_monitor.sv ----
// Port checker for the host page, lock and status bank.
`timescale 1ns/100ps
module hplsb_bank_chk (
  input wire logic                         core_clk_in,
  input wire logic                         resetn_in,
  input wire logic                         req_valid_in,
  input wire hplsb_pkg::hplsb_req_t        req_in,
  input wire logic                         access_fail_in,
  input wire logic                         rsp_valid_out,
  input wire logic                         rsp_hit_out,
  input wire logic [hplsb_pkg::DATA_W-1:0] rsp_rdata_out,
  input wire logic [hplsb_pkg::PAGE_W-1:0] page_out,
  input wire logic                         lock_active_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire pw  = req_valid_in && req_in.write && req_in.offset == 7'h7F;
  wire gd  = req_valid_in && req_in.offset == 7'h7E && page_out == 8'h02;
  wire okc = req_in.wdata <= 8'h0D && req_in.wdata != 8'h07 && req_in.wdata != 8'h09;
  a_rsp_one_cycle: assert property (req_valid_in |=> rsp_valid_out) else $error("no answer");
  a_rsp_no_extra: assert property (!req_valid_in |=> !rsp_valid_out && !rsp_hit_out)
    else $error("stray answer");
  a_page_take: assert property (pw && okc && !lock_active_out |=> page_out == $past(req_in.wdata))
    else $error("page not taken");
  a_page_lock_hold: assert property (pw && lock_active_out |=> $stable(page_out))
    else $error("locked page moved");
  a_page_code_legal: assert property (page_out <= 8'h0D && page_out != 8'h07 && page_out != 8'h09)
    else $error("reserved page held");
  a_lock_follows: assert property (gd && req_in.write |=>
    lock_active_out == ($past(req_in.wdata) != 8'h00)) else $error("lock flag wrong");
  a_write_reads_zero: assert property (req_valid_in && req_in.write |=> rsp_rdata_out == 8'h00)
    else $error("write data nonzero");
  a_fail_seen: assert property (access_fail_in ##1 !req_valid_in ##1 gd && !req_in.write |=>
    rsp_rdata_out == 8'h01) else $error("failure not shown");
  a_refuse_seen: assert property (pw && (lock_active_out || !okc) ##1 !req_valid_in
    ##1 gd && !req_in.write |=> rsp_rdata_out == 8'h01) else $error("refusal not shown");
  a_guard_clean: assert property (req_valid_in && !access_fail_in && !pw
    ##1 !req_valid_in && !access_fail_in ##1 gd && !req_in.write |=> rsp_rdata_out == 8'h00)
    else $error("guard not clear");
  a_idle_hold: assert property (!req_valid_in |=> $stable(page_out) && $stable(lock_active_out))
    else $error("state moved idle");
  c_lock_write: cover property (pw && lock_active_out);
  c_fail_only: cover property (access_fail_in && !req_valid_in);
  c_guard_write: cover property (gd && req_in.write);
endmodule
bind hplsb_bank hplsb_bank_chk u_hplsb_bank_chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .access_fail_in(access_fail_in), .rsp_valid_out(rsp_valid_out),
  .rsp_hit_out(rsp_hit_out), .rsp_rdata_out(rsp_rdata_out), .page_out(page_out), .lock_active_out(lock_active_out));

// ---- sim/hplsb_host.sv ----
// Host processor model issuing single-byte requests over the serial port.
`timescale 1ns/100ps
module hplsb_host (
  // Clock.
  input  wire logic             core_clk_in,
  // Requests toward the bank.
  output logic                  req_valid_out,
  output hplsb_pkg::hplsb_req_t req_out,
  output logic                  fail_out
);
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
    fail_out = 1'b0;
  end
  // Reserved page codes go out only when a scenario asks for them
  task automatic xfer(input logic v, input logic w, input logic [6:0] o, input logic [7:0] d, input logic f);
    @(posedge core_clk_in);
    req_valid_out <= v;
    req_out <= '{write: w, offset: o, wdata: d};
    fail_out <= f;
    @(posedge core_clk_in);
    req_valid_out <= 1'b0;
    fail_out <= 1'b0;
    req_out <= ~req_out;
  endtask
endmodule

// ---- sim/hplsb_bank_tb.sv ----
// Self-checking bench for the host page, lock and status bank.
`timescale 1ns/100ps
module hplsb_bank_tb;
  typedef struct packed {logic w; logic [6:0] o; logic [7:0] d; logic h; logic [7:0] e;} hplsb_row_t;
  localparam hplsb_row_t ROWS [26] = '{'{1,7'h7F,8'h02,1,8'h00}, '{0,7'h7F,8'h00,1,8'h02}, '{0,7'h7E,8'h00,1,8'h00},
    '{1,7'h7F,8'h07,1,8'h00}, '{0,7'h7E,8'h00,1,8'h01}, '{0,7'h7E,8'h00,1,8'h00}, '{1,7'h7F,8'h09,1,8'h00},
    '{0,7'h7E,8'h00,1,8'h01}, '{1,7'h7F,8'hFF,1,8'h00}, '{0,7'h7E,8'h00,1,8'h01}, '{1,7'h6F,8'hFF,1,8'h00},
    '{0,7'h6F,8'h00,1,8'h00}, '{0,7'h70,8'h00,1,8'h00}, '{0,7'h71,8'h00,1,8'h00}, '{0,7'h00,8'h00,0,8'h00},
    '{1,7'h7F,8'h0D,1,8'h00}, '{0,7'h7F,8'h00,1,8'h0D}, '{0,7'h6F,8'h00,0,8'h00}, '{1,7'h7F,8'h02,1,8'h00},
    '{1,7'h7E,8'h01,1,8'h00}, '{1,7'h7F,8'h05,1,8'h00}, '{0,7'h7E,8'h00,1,8'h01}, '{0,7'h7F,8'h00,1,8'h02},
    '{1,7'h7E,8'h00,1,8'h00}, '{0,7'h7E,8'h00,1,8'h00}, '{1,7'h7F,8'h02,1,8'h00}};
  logic                  core_clk_in = 1'b0;
  logic                  resetn_in = 1'b0;
  logic                  req_valid_in;
  logic                  access_fail_in;
  hplsb_pkg::hplsb_req_t req_in;
  hplsb_pkg::hplsb_mon_t mon_one_in = '0;
  hplsb_pkg::hplsb_mon_t mon_two_in = '0;
  hplsb_pkg::hplsb_mon_t mon_three_in = '0;
  logic                  rsp_valid_out;
  logic                  rsp_hit_out;
  logic                  lock_active_out;
  logic [7:0]            rsp_rdata_out;
  logic [7:0]            page_out;
  int                    n_fail = 0;
  int                    total_checks = 0;
  always #10 core_clk_in = ~core_clk_in;
  hplsb_host u_hplsb_host (.core_clk_in(core_clk_in), .req_valid_out(req_valid_in), .req_out(req_in),
    .fail_out(access_fail_in));
  hplsb_bank u_hplsb_bank (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .access_fail_in(access_fail_in), .mon_one_in(mon_one_in), .mon_two_in(mon_two_in),
    .mon_three_in(mon_three_in), .rsp_valid_out(rsp_valid_out), .rsp_hit_out(rsp_hit_out),
    .rsp_rdata_out(rsp_rdata_out), .page_out(page_out), .lock_active_out(lock_active_out));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic op(input logic w, input logic [6:0] o, input logic [7:0] d, input logic h, input logic [7:0] e);
    u_hplsb_host.xfer(1'b1, w, o, d, 1'b0);
    #1;
    chk("rsp_valid", {7'h00, rsp_valid_out}, 8'h01);
    chk("rsp_hit", {7'h00, rsp_hit_out}, {7'h00, h});
    chk("rsp_rdata", rsp_rdata_out, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    foreach (ROWS[i]) begin
      op(ROWS[i].w, ROWS[i].o, ROWS[i].d, ROWS[i].h, ROWS[i].e);
    end
    @(posedge core_clk_in);
    mon_one_in <= '{4'hF, 4'hF, 1'b1, 1'b1};
    mon_two_in <= '{4'hA, 4'hF, 1'b1, 1'b0};
    mon_three_in <= '{4'hF, 4'hF, 1'b1, 1'b1};
    repeat (5) @(posedge core_clk_in);
    op(1'b0, 7'h6F, 8'h00, 1'b1, 8'hF4);
    op(1'b0, 7'h70, 8'h00, 1'b1, 8'hA0);
    op(1'b0, 7'h71, 8'h00, 1'b1, 8'h34);
    @(posedge core_clk_in);
    mon_one_in <= '{4'hF, 4'h5, 1'b1, 1'b0};
    mon_two_in <= '{4'hF, 4'hF, 1'b0, 1'b1};
    repeat (5) @(posedge core_clk_in);
    op(1'b0, 7'h6F, 8'h00, 1'b1, 8'h50);
    op(1'b0, 7'h70, 8'h00, 1'b1, 8'h04);
    u_hplsb_host.xfer(1'b0, 1'b0, 7'h00, 8'h00, 1'b1);
    op(1'b0, 7'h7E, 8'h00, 1'b1, 8'h01);
    op(1'b1, 7'h7E, 8'h01, 1'b1, 8'h00);
    chk("lock", {7'h00, lock_active_out}, 8'h01);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    #1;
    chk("page_rst", page_out, 8'h00);
    chk("lock_rst", {7'h00, lock_active_out}, 8'h00);
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    op(1'b0, 7'h7F, 8'h00, 1'b1, 8'h00);
    op(1'b1, 7'h7F, 8'h03, 1'b1, 8'h00);
    chk("page", page_out, 8'h03);
    op(1'b0, 7'h7F, 8'h00, 1'b1, 8'h03);
    summarize();
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule
